// >>> logic/cpec_top.sv
// Code protect, erase and read-back engine for nonvolatile memory
`default_nettype none
module cpec_top (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [31:0] reg_rdata,
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire logic [2:0]  cmd_op,
   input  wire logic [23:0] cmd_addr,
   input  wire logic [23:0] cmd_data,
   input  wire logic        cmd_single_panel,
   output logic             rsp_valid,
   output logic             rsp_ok,
   output logic      [23:0] rsp_data,
   output logic             engine_reset
);
   typedef enum logic [0:0] {ST_IDLE, ST_ERASE} cpec_state_t;

   cpec_state_t               state;
   logic [31:0]               ctrl;
   logic                      last_ok;
   logic [23:0]               code_mem [cpec_pkg::CODE_WORDS];
   logic [23:0]               uid_mem [cpec_pkg::UID_WORDS];
   logic [15:0]               cfg [cpec_pkg::CFG_COUNT];
   logic [cpec_pkg::CODE_AW-1:0] er_idx;
   logic [cpec_pkg::CODE_AW-1:0] er_last;
   logic                      accept;
   logic [cpec_pkg::CODE_AW-1:0] widx;
   logic [cpec_pkg::UID_AW-1:0]  uidx;
   logic [2:0]                cidx;
   logic                      code_hit;
   logic                      uid_hit;
   logic                      cfg_hit;
   logic                      devid_hit;
   logic [15:0]               boot_protect_reg;
   logic [15:0]               general_protect_reg;
   logic                      boot_defined;
   logic                      in_boot;
   logic                      seg_wp;
   logic                      seg_rp;
   logic                      locked;
   logic                      code_write_ok;
   logic                      row_erase_ok;
   logic                      read_valid;
   logic                      is_read;
   logic                      do_chip;
   logic                      do_general;
   logic [15:0]               devid_word;
   logic [15:0]               unimpl_or;
   logic [12:0]               busy_cnt;

   assign boot_protect_reg = cfg[cpec_pkg::CFG_BOOT];
   assign general_protect_reg = cfg[cpec_pkg::CFG_GENERAL];
   assign cmd_ready = (state == ST_IDLE) && ctrl[cpec_pkg::CTRL_ENABLE];
   assign accept = cmd_valid && cmd_ready;

   // Address decode
   assign widx = cmd_addr[cpec_pkg::CODE_AW:1];
   assign uidx = cmd_addr[cpec_pkg::UID_AW:1];
   assign cidx = cmd_addr[3:1];
   assign code_hit = cmd_addr <= cpec_pkg::CODE_LAST_ADDR;
   assign uid_hit = (cmd_addr >= cpec_pkg::UID_FIRST_ADDR) && (cmd_addr <= cpec_pkg::UID_LAST_ADDR);
   assign cfg_hit = (cmd_addr[23:4] == cpec_pkg::CFG_BASE_ADDR[23:4]) && !cmd_addr[0]
                    && (int'(cidx) < cpec_pkg::CFG_COUNT);
   assign devid_hit = (cmd_addr[23:2] == cpec_pkg::DEVID_BASE_ADDR[23:2]) && !cmd_addr[0];
   assign devid_word = cmd_addr[1] ? cpec_pkg::DEVID_WORD1 : cpec_pkg::DEVID_WORD0;

   // Segment protection state
   assign boot_defined = boot_protect_reg[cpec_pkg::BSS_LSB+2:cpec_pkg::BSS_LSB+1] != cpec_pkg::BSS_NO_BOOT;
   assign in_boot = boot_defined && (int'(widx) < cpec_pkg::BOOT_WORDS);
   assign seg_wp = in_boot ? !boot_protect_reg[cpec_pkg::BOOT_WRITE_PROTECT_BIT_BIT] : !general_protect_reg[cpec_pkg::GENERAL_WRITE_PROTECT_BIT_BIT];
   assign seg_rp = in_boot ? !boot_protect_reg[cpec_pkg::BSS_LSB]
                           : (general_protect_reg[cpec_pkg::GSS_LSB+1:cpec_pkg::GSS_LSB] == cpec_pkg::GSS_READ_PROT);
   // any protect bit clear locks code
   assign locked = ((boot_protect_reg & cpec_pkg::CFG_MASK[0]) != cpec_pkg::CFG_MASK[0])
                   || ((general_protect_reg & cpec_pkg::CFG_MASK[1]) != cpec_pkg::CFG_MASK[1]);
   // write and read protect refuse programming
   assign code_write_ok = uid_hit || (code_hit && !locked && !seg_wp && !seg_rp);
   assign row_erase_ok = code_hit && !locked;
   assign is_read = (cmd_op == cpec_pkg::OP_CONFIG_READ) || (cmd_op == cpec_pkg::OP_CODE_READ);
   assign read_valid = (cmd_op == cpec_pkg::OP_CONFIG_READ) ? (cfg_hit || devid_hit) : (code_hit || uid_hit);
   assign do_chip = accept && (cmd_op == cpec_pkg::OP_BULK_ERASE) && (cmd_data[1:0] == cpec_pkg::ERASE_CHIP);
   assign do_general = accept && (cmd_op == cpec_pkg::OP_BULK_ERASE)
                       && (cmd_data[1:0] == cpec_pkg::ERASE_GENERAL) && !(boot_defined && !boot_protect_reg[cpec_pkg::BOOT_WRITE_PROTECT_BIT_BIT]);

   // Software control register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= cpec_pkg::CTRL_RESET;
      end else if (reg_write && (reg_addr == cpec_pkg::REG_CTRL)) begin
         ctrl <= reg_wdata & 32'h00000001;
      end
   end

   // Software read port, unmapped reads zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_read && (reg_addr == cpec_pkg::REG_CTRL)) begin
         reg_rdata <= ctrl;
      end else if (reg_read && (reg_addr == cpec_pkg::REG_STATUS)) begin
         reg_rdata <= {28'h0000000, boot_defined, locked, last_ok, state == ST_ERASE};
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   // Sequencer and erase range
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         er_idx <= 12'h000;
         er_last <= 12'h000;
      end else begin
         case (state)
            ST_IDLE: begin
               if (do_chip) begin
                  state <= ST_ERASE;
                  er_idx <= 12'h000;
                  er_last <= 12'hfff;
               end else if (do_general) begin
                  state <= ST_ERASE;
                  er_idx <= boot_defined ? 12'h100 : 12'h000;
                  er_last <= 12'hfff;
               end else if (accept && (cmd_op == cpec_pkg::OP_ROW_ERASE) && row_erase_ok) begin
                  // only the addressed row, protection untouched
                  state <= ST_ERASE;
                  er_idx <= {widx[cpec_pkg::CODE_AW-1:cpec_pkg::ROW_AW], 5'h00};
                  er_last <= {widx[cpec_pkg::CODE_AW-1:cpec_pkg::ROW_AW], 5'h1f};
               end
            end
            ST_ERASE: begin
               if (er_idx == er_last) begin
                  state <= ST_IDLE;
               end else begin
                  er_idx <= er_idx + 12'h001;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Code and unit ID arrays
   always_ff @(posedge clk) begin
      if (state == ST_ERASE) begin
         code_mem[er_idx] <= cpec_pkg::ALL_ONES;
      end else if (accept && (cmd_op == cpec_pkg::OP_CODE_WRITE) && code_write_ok && code_hit) begin
         code_mem[widx] <= cmd_data;
      end
   end

   always_ff @(posedge clk) begin
      // unit ID written like executive memory
      if (accept && (cmd_op == cpec_pkg::OP_CODE_WRITE) && uid_hit) begin
         uid_mem[uidx] <= cmd_data;
      end
   end

   // Configuration registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < cpec_pkg::CFG_COUNT; i++) begin
            cfg[i] <= cpec_pkg::CFG_MASK[i];
         end
      end else if (do_chip) begin
         cfg[cpec_pkg::CFG_BOOT] <= cpec_pkg::CFG_MASK[0];
         cfg[cpec_pkg::CFG_GENERAL] <= cpec_pkg::CFG_MASK[1];
      end else if (do_general) begin
         // general segment erase restores its register
         cfg[cpec_pkg::CFG_GENERAL] <= cpec_pkg::CFG_MASK[1];
      end else if (accept && (cmd_op == cpec_pkg::OP_CONFIG_WRITE) && cfg_hit) begin
         // one word, masked, protect bits only clear
         if ((cidx == cpec_pkg::CFG_BOOT) || (cidx == cpec_pkg::CFG_GENERAL)) begin
            cfg[cidx] <= cfg[cidx] & cmd_data[15:0] & cpec_pkg::CFG_MASK[cidx];
         end else begin
            cfg[cidx] <= cmd_data[15:0] & cpec_pkg::CFG_MASK[cidx];
         end
      end
   end

   // Responses
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rsp_valid <= 1'b0;
         rsp_ok <= 1'b0;
         rsp_data <= 24'h000000;
         engine_reset <= 1'b0;
         last_ok <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         engine_reset <= 1'b0;
         if ((state == ST_ERASE) && (er_idx == er_last)) begin
            rsp_valid <= 1'b1;
            rsp_ok <= 1'b1;
            rsp_data <= 24'h000000;
            last_ok <= 1'b1;
         end else if (accept && is_read && !read_valid) begin
            // bad read address resets the engine
            engine_reset <= 1'b1;
            last_ok <= 1'b0;
         end else if (accept) begin
            rsp_valid <= (state == ST_IDLE) && !(do_chip || do_general
                         || ((cmd_op == cpec_pkg::OP_ROW_ERASE) && row_erase_ok));
            rsp_data <= 24'h000000;
            case (cmd_op)
               cpec_pkg::OP_CONFIG_WRITE: begin
                  rsp_ok <= cfg_hit;
                  last_ok <= cfg_hit;
               end
               cpec_pkg::OP_CODE_WRITE: begin
                  rsp_ok <= code_write_ok;
                  last_ok <= code_write_ok;
               end
               cpec_pkg::OP_CONFIG_READ: begin
                  rsp_ok <= 1'b1;
                  last_ok <= 1'b1;
                  rsp_data <= {8'h00, cfg_hit ? cfg[cidx] : devid_word};
               end
               cpec_pkg::OP_CODE_READ: begin
                  rsp_ok <= 1'b1;
                  last_ok <= 1'b1;
                  if (uid_hit) begin
                     rsp_data <= uid_mem[uidx];
                  end else if (!seg_rp) begin
                     rsp_data <= code_mem[widx];
                  end
               end
               default: begin
                  // Refused erases and unknown commands
                  rsp_ok <= 1'b0;
                  last_ok <= 1'b0;
               end
            endcase
         end
      end
   end

   // Erase cycle count for the row length check
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_cnt <= 13'h0000;
      end else if (state == ST_ERASE) begin
         busy_cnt <= busy_cnt + 13'h0001;
      end else begin
         busy_cnt <= 13'h0000;
      end
   end

   // Helper for unimplemented bit check
   always_comb begin
      unimpl_or = 16'h0000;
      for (int i = 0; i < cpec_pkg::CFG_COUNT; i++) begin
         unimpl_or = unimpl_or | (cfg[i] & ~cpec_pkg::CFG_MASK[i]);
      end
   end

   chk_unimpl_zero: assert property (@(posedge clk) disable iff (!reset_n)
      unimpl_or == 16'h0000) else $error("unimplemented config bit set");

   chk_sysreg_kept: assert property (@(posedge clk) disable iff (!reset_n)
      do_chip |=> $stable(cfg[2]) && $stable(cfg[3]) && $stable(cfg[4]) && $stable(cfg[5]) && $stable(cfg[6]))
      else $error("chip erase changed a system register");

   chk_chip_unprotect: assert property (@(posedge clk) disable iff (!reset_n)
      do_chip |=> (boot_protect_reg == 16'h000f) && (general_protect_reg == 16'h0007) && !locked)
      else $error("chip erase left protection set");

   chk_prot_only_clear: assert property (@(posedge clk) disable iff (!reset_n)
      ((boot_protect_reg & ~$past(boot_protect_reg)) != 16'h0000) |-> $past(do_chip))
      else $error("boot protect bit rose without chip erase");

   chk_gen_only_clear: assert property (@(posedge clk) disable iff (!reset_n)
      ((general_protect_reg & ~$past(general_protect_reg)) != 16'h0000) |-> $past(do_chip || do_general))
      else $error("general protect bit rose without erase");

   chk_wp_fails: assert property (@(posedge clk) disable iff (!reset_n)
      accept && (cmd_op == cpec_pkg::OP_CODE_WRITE) && code_hit && seg_wp
      |=> rsp_valid && !rsp_ok) else $error("write under write protection accepted");

   chk_rp_write_fails: assert property (@(posedge clk) disable iff (!reset_n)
      accept && (cmd_op == cpec_pkg::OP_CODE_WRITE) && code_hit && seg_rp
      |=> rsp_valid && !rsp_ok) else $error("write under read protection accepted");

   chk_locked_fails: assert property (@(posedge clk) disable iff (!reset_n)
      accept && (cmd_op == cpec_pkg::OP_ROW_ERASE) && locked
      |=> rsp_valid && !rsp_ok && (state == ST_IDLE)) else $error("row erase while locked");

   chk_rp_read_zero: assert property (@(posedge clk) disable iff (!reset_n)
      accept && (cmd_op == cpec_pkg::OP_CODE_READ) && code_hit && seg_rp
      |=> rsp_valid && (rsp_data == 24'h000000)) else $error("protected read leaked data");

   chk_cfg_read_width: assert property (@(posedge clk) disable iff (!reset_n)
      accept && (cmd_op == cpec_pkg::OP_CONFIG_READ) && read_valid
      |=> rsp_valid && (rsp_data[23:16] == 8'h00)) else $error("config read wider than 16 bits");

   chk_bad_read_reset: assert property (@(posedge clk) disable iff (!reset_n)
      accept && is_read && !read_valid |=> engine_reset && !rsp_valid)
      else $error("invalid read did not reset engine");

   chk_row_erase_len: assert property (@(posedge clk) disable iff (!reset_n)
      accept && (cmd_op == cpec_pkg::OP_ROW_ERASE) && row_erase_ok
      |-> ##32 (state == ST_ERASE) && (busy_cnt == 13'(cpec_pkg::ROW_WORDS - 1))
      ##1 (state == ST_IDLE) && rsp_valid && rsp_ok)
      else $error("row erase not exactly one row");

   chk_row_keeps_prot: assert property (@(posedge clk) disable iff (!reset_n)
      (accept && (cmd_op == cpec_pkg::OP_ROW_ERASE)) || (state == ST_ERASE) |=> $stable(boot_protect_reg) && $stable(general_protect_reg))
      else $error("erase loop touched protection");

endmodule
`default_nettype wire

// >>> shared/cpec_pkg.sv
// Constants and types for the code protect and erase control block
`default_nettype none
package cpec_pkg;
   // Memory geometry, program-counter addresses step by two
   localparam int          CODE_WORDS     = 4096;
   localparam int          CODE_AW        = 12;
   localparam int          UID_WORDS      = 32;
   localparam int          UID_AW         = 5;
   localparam int          ROW_WORDS      = 32;
   localparam int          ROW_AW         = 5;
   localparam int          BOOT_WORDS     = 256;
   localparam logic [23:0] CODE_LAST_ADDR = 24'h001ffe;
   localparam logic [23:0] UID_FIRST_ADDR = 24'h8005c0;
   localparam logic [23:0] UID_LAST_ADDR  = 24'h8005ff;
   localparam logic [23:0] CFG_BASE_ADDR  = 24'hf80000;
   localparam logic [23:0] DEVID_BASE_ADDR = 24'hff0000;
   localparam int          CFG_COUNT      = 7;
   localparam logic [23:0] ALL_ONES       = 24'hffffff;
   // Device identification words, values are arbitrary
   localparam logic [15:0] DEVID_WORD0    = 16'h0a5c;
   localparam logic [15:0] DEVID_WORD1    = 16'h0003;
   // Configuration register indices
   localparam logic [2:0]  CFG_BOOT       = 3'h0;
   localparam logic [2:0]  CFG_GENERAL    = 3'h1;
   // Implemented bit masks, one per configuration register
   localparam logic [15:0] CFG_MASK [CFG_COUNT] = '{16'h000f, 16'h0007, 16'h0003, 16'h00e7,
                                                    16'h00df, 16'h0007, 16'h0083};
   // Protection field positions
   localparam int          BOOT_WRITE_PROTECT_BIT_BIT       = 0;
   localparam int          BSS_LSB        = 1;
   localparam int          GENERAL_WRITE_PROTECT_BIT_BIT       = 0;
   localparam int          GSS_LSB        = 1;
   localparam logic [1:0]  GSS_READ_PROT  = 2'h2;
   localparam logic [1:0]  BSS_NO_BOOT    = 2'h3;
   // Bulk erase modes in the low data bits
   localparam logic [1:0]  ERASE_CHIP     = 2'h0;
   localparam logic [1:0]  ERASE_GENERAL  = 2'h1;
   // Software register offsets and bits
   localparam logic [7:0]  REG_CTRL       = 8'h00;
   localparam logic [7:0]  REG_STATUS     = 8'h04;
   localparam int          CTRL_ENABLE    = 0;
   localparam logic [31:0] CTRL_RESET     = 32'h00000000;
   typedef enum logic [2:0] {
      OP_BULK_ERASE   = 3'h0,
      OP_ROW_ERASE    = 3'h1,
      OP_CONFIG_WRITE = 3'h2,
      OP_CODE_WRITE   = 3'h3,
      OP_CONFIG_READ  = 3'h4,
      OP_CODE_READ    = 3'h5
   } cpec_op_t;
endpackage
`default_nettype wire

// >>> test/cpec_programmer.sv
// Programmer model driving the command port of the protect engine
`default_nettype none
module cpec_programmer (
   input  wire logic        clk,
   input  wire logic        cmd_ready,
   input  wire logic        rsp_valid,
   input  wire logic        rsp_ok,
   input  wire logic [23:0] rsp_data,
   input  wire logic        engine_reset,
   output logic             cmd_valid,
   output logic      [2:0]  cmd_op,
   output logic      [23:0] cmd_addr,
   output logic      [23:0] cmd_data,
   output logic             cmd_single_panel
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cmd_valid = 1'b0;
      cmd_op = 3'h7;
      cmd_addr = 24'h0;
      cmd_data = 24'h0;
      cmd_single_panel = 1'b0;
   end

   // One command, held until taken, then wait for its answer
   task automatic cmd(input logic [2:0] op, input logic [23:0] a, input logic [23:0] d,
                      output logic ok, output logic [23:0] r, output logic rst, output int lat);
      int n;
      ok = 1'b0;
      r = 24'h0;
      rst = 1'b0;
      lat = 0;
      n = 0;
      @(posedge clk);
      cmd_op <= op;
      cmd_addr <= a;
      cmd_data <= d;
      cmd_single_panel <= 1'b1;
      cmd_valid <= 1'b1;
      do begin
         @(negedge clk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 100);
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_op <= ~op;
      cmd_addr <= ~a;
      cmd_data <= ~d;
      for (int i = 1; i < 5000; i++) begin
         @(negedge clk);
         if (rsp_valid === 1'b1 || engine_reset === 1'b1) begin
            ok = rsp_ok;
            r = rsp_data;
            rst = engine_reset;
            lat = i;
            break;
         end
      end
   endtask

   // Config word write followed by read-back; raw skips masking
   task automatic cfg_wr(input logic [2:0] idx, input logic [15:0] d, input logic raw, output logic [15:0] rb);
      logic        ok;
      logic        rst;
      logic [23:0] r;
      logic [23:0] a;
      int          lat;
      a = cpec_pkg::CFG_BASE_ADDR + {20'h0, idx, 1'b0};
      cmd(cpec_pkg::OP_CONFIG_WRITE, a, {8'h0, raw ? d : d & cpec_pkg::CFG_MASK[idx]}, ok, r, rst, lat);
      cmd(cpec_pkg::OP_CONFIG_READ, a, 24'h0, ok, r, rst, lat);
      rb = r[15:0];
   endtask

   // boot size read before segment erase
   task automatic boot_defined(output logic bd);
      logic        ok;
      logic        rst;
      logic [23:0] r;
      int          lat;
      cmd(cpec_pkg::OP_CONFIG_READ, cpec_pkg::CFG_BASE_ADDR, 24'h0, ok, r, rst, lat);
      bd = (r[3:2] != 2'b11);
      if (bd) begin
         $display("Warning to user: boot segment defined");
      end
   endtask
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the code protect and erase engine
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, reset_n, reg_write, reg_read, cmd_valid, cmd_ready, cmd_single_panel;
   logic        rsp_valid, rsp_ok, engine_reset, ok, rst, bd;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd;
   logic [2:0]  cmd_op;
   logic [23:0] cmd_addr, cmd_data, rsp_data, r;
   logic [15:0] rb;
   int          fails, samples_checked, lat;

   cpec_top cpec_top_i (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_data, .cmd_single_panel, .rsp_valid, .rsp_ok,
      .rsp_data, .engine_reset);
   cpec_programmer cpec_programmer_i (.clk, .cmd_ready, .rsp_valid, .rsp_ok, .rsp_data, .engine_reset,
      .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .cmd_single_panel);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic stop_test();
      $display("Counts: %0d checked, %0d mismatches", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      @(negedge clk);
      rd = reg_rdata;
   endtask

   task automatic c(input logic [2:0] o, input logic [23:0] a, input logic [23:0] d);
      cpec_programmer_i.cmd(o, a, d, ok, r, rst, lat);
   endtask

   task automatic cr(input logic [23:0] a, input logic [23:0] e);
      c(cpec_pkg::OP_CODE_READ, a, 24'h0);
      check("code read", r, e);
   endtask

   task automatic fr(input logic [2:0] i, input logic [23:0] e);
      c(cpec_pkg::OP_CONFIG_READ, cpec_pkg::CFG_BASE_ADDR + {20'h0, i, 1'b0}, 24'h0);
      check("config read", r, e);
   endtask

   task automatic cw(input logic [23:0] a, input logic [23:0] d, input logic e);
      c(cpec_pkg::OP_CODE_WRITE, a, d);
      check("code write ok", ok, e);
   endtask

   task automatic erase(input logic [1:0] m, input logic e);
      c(cpec_pkg::OP_BULK_ERASE, 24'h0, {22'h0, m});
      check("bulk erase ok", ok, e);
   endtask

   initial begin
      #500us;
      fails++;
      stop_test();
   end

   initial begin
      fails = 0;
      samples_checked = 0;
      reset_n = 1'b0;
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      reg_rd(cpec_pkg::REG_CTRL);
      check("ctrl reset", rd, cpec_pkg::CTRL_RESET);
      reg_rd(8'h08);
      check("unmapped read", rd, 32'h0);
      reg_wr(cpec_pkg::REG_CTRL, 32'hffffffff);
      reg_rd(cpec_pkg::REG_CTRL);
      check("ctrl enable", rd, 32'h1);
      $display("test registers done");
      erase(cpec_pkg::ERASE_CHIP, 1'b1);
      cr(24'h0, cpec_pkg::ALL_ONES);
      cr(cpec_pkg::CODE_LAST_ADDR, cpec_pkg::ALL_ONES);
      fr(cpec_pkg::CFG_BOOT, 24'h00000f);
      reg_rd(cpec_pkg::REG_STATUS);
      check("status idle", rd, 32'h2);
      cpec_programmer_i.cfg_wr(3'h3, 16'hffff, 1'b1, rb);
      check("unimplemented bits", rb, 16'h00e7);
      cpec_programmer_i.cfg_wr(3'h3, 16'h00a5, 1'b0, rb);
      check("config word", rb, 16'h00a5);
      c(cpec_pkg::OP_CONFIG_WRITE, 24'h000010, 24'h0);
      check("config non-config addr", ok, 1'b0);
      $display("test config done");
      cw(24'h000010, 24'h123456, 1'b1);
      cw(24'h000040, 24'h654321, 1'b1);
      c(cpec_pkg::OP_ROW_ERASE, 24'h0, 24'h0);
      check("row erase latency", lat, 33);
      cr(24'h000010, cpec_pkg::ALL_ONES);
      cr(24'h000040, 24'h654321);
      cw(cpec_pkg::UID_FIRST_ADDR, 24'h0a0b0c, 1'b1);
      cw(24'h8005fe, 24'h0d0e0f, 1'b1);
      cr(cpec_pkg::UID_FIRST_ADDR, 24'h0a0b0c);
      cr(24'h8005fe, 24'h0d0e0f);
      $display("test rows and unit id done");
      erase(cpec_pkg::ERASE_CHIP, 1'b1);
      fr(3'h3, 24'h0000a5);
      c(cpec_pkg::OP_CONFIG_READ, cpec_pkg::DEVID_BASE_ADDR, 24'h0);
      check("device id", r, {8'h0, cpec_pkg::DEVID_WORD0});
      c(cpec_pkg::OP_CONFIG_READ, cpec_pkg::DEVID_BASE_ADDR + 24'h000002, 24'h0);
      check("device id high", r, {8'h0, cpec_pkg::DEVID_WORD1});
      erase(2'h2, 1'b0);
      cr(24'h000040, cpec_pkg::ALL_ONES);
      $display("test chip erase done");
      cw(24'h000020, 24'habcdef, 1'b1);
      cpec_programmer_i.cfg_wr(cpec_pkg::CFG_GENERAL, 16'h0006, 1'b0, rb);
      check("general write protect", rb, 16'h0006);
      cw(24'h000030, 24'h000001, 1'b0);
      cr(24'h000030, cpec_pkg::ALL_ONES);
      cpec_programmer_i.cfg_wr(cpec_pkg::CFG_GENERAL, 16'h0007, 1'b0, rb);
      check("protect bit stays clear", rb, 16'h0006);
      c(cpec_pkg::OP_ROW_ERASE, 24'h0, 24'h0);
      check("row erase locked", ok, 1'b0);
      fr(cpec_pkg::CFG_GENERAL, 24'h000006);
      cr(24'h000020, 24'habcdef);
      cpec_programmer_i.boot_defined(bd);
      erase(cpec_pkg::ERASE_GENERAL, 1'b1);
      fr(cpec_pkg::CFG_GENERAL, 24'h000007);
      cr(24'h000020, cpec_pkg::ALL_ONES);
      $display("test write protect done");
      cw(24'h000020, 24'habcdef, 1'b1);
      cpec_programmer_i.cfg_wr(cpec_pkg::CFG_GENERAL, 16'h0005, 1'b0, rb);
      cr(24'h000020, 24'h0);
      cw(24'h000022, 24'h000001, 1'b0);
      erase(cpec_pkg::ERASE_CHIP, 1'b1);
      fr(cpec_pkg::CFG_GENERAL, 24'h000007);
      cr(24'h000020, cpec_pkg::ALL_ONES);
      $display("test read protect done");
      cpec_programmer_i.cfg_wr(cpec_pkg::CFG_BOOT, 16'h0002, 1'b0, rb);
      check("boot protect", rb, 16'h0002);
      reg_rd(cpec_pkg::REG_STATUS);
      check("boot defined flag", rd[3], 1'b1);
      cpec_programmer_i.boot_defined(bd);
      erase(cpec_pkg::ERASE_GENERAL, 1'b0);
      cw(24'h000000, 24'h000001, 1'b0);
      erase(cpec_pkg::ERASE_CHIP, 1'b1);
      fr(cpec_pkg::CFG_BOOT, 24'h00000f);
      cw(24'h000000, 24'h111111, 1'b1);
      cw(24'h000200, 24'h222222, 1'b1);
      cpec_programmer_i.cfg_wr(cpec_pkg::CFG_BOOT, 16'h000b, 1'b0, rb);
      cpec_programmer_i.boot_defined(bd);
      erase(cpec_pkg::ERASE_GENERAL, 1'b1);
      cr(24'h000000, 24'h111111);
      cr(24'h000200, cpec_pkg::ALL_ONES);
      erase(cpec_pkg::ERASE_CHIP, 1'b1);
      $display("test boot segment done");
      c(cpec_pkg::OP_CONFIG_READ, 24'hf8000e, 24'h0);
      check("engine reset config", rst, 1'b1);
      c(cpec_pkg::OP_CODE_READ, 24'h002000, 24'h0);
      check("engine reset code", rst, 1'b1);
      c(cpec_pkg::OP_CODE_READ, 24'h800600, 24'h0);
      check("engine reset unit id", rst, 1'b1);
      cr(24'h0, cpec_pkg::ALL_ONES);
      $display("test invalid reads done");
      stop_test();
   end
endmodule
`default_nettype wire
